// File: include/neac_defines.vh
// constants for the data nonvolatile access unit
`ifndef NEAC_DEFINES_VH
`define NEAC_DEFINES_VH

// i/o register offsets
`define NEAC_OFF_CTRL       6'h00
`define NEAC_OFF_DATA       6'h01
`define NEAC_OFF_ADDR_LO    6'h02
`define NEAC_OFF_ADDR_HI    6'h03

// control register fields
`define NEAC_CTRL_RD_BIT    0
`define NEAC_CTRL_WR_BIT    1
`define NEAC_CTRL_ARM_BIT   2
`define NEAC_CTRL_MODE_LO   4
`define NEAC_CTRL_MODE_HI   5

// storage geometry
`define NEAC_DEPTH          512
`define NEAC_AW             9

// programming modes
`define NEAC_MODE_ATOMIC    2'h0
`define NEAC_MODE_ERASE     2'h1
`define NEAC_MODE_WRITE     2'h2
`define NEAC_MODE_RSVD      2'h3

// reset values and the erased byte value
`define NEAC_RST_MODE       2'h0
`define NEAC_RST_ADDR       9'h000
`define NEAC_RST_DATA       8'h00
`define NEAC_ERASED_BYTE    8'hFF

// timing: cpu stall cycles and arming window
`define NEAC_RD_STALL       3'h4
`define NEAC_WR_STALL       3'h2
`define NEAC_ARM_WINDOW     3'h4

// programming times in microseconds, oscillator rate in MHz
`define NEAC_T_ATOMIC_US    16'h0D48
`define NEAC_T_SPLIT_US     16'h0708
`define NEAC_OSC_MHZ        16'h0008
`define NEAC_ATOMIC_TICKS   (`NEAC_T_ATOMIC_US * `NEAC_OSC_MHZ)
`define NEAC_SPLIT_TICKS    (`NEAC_T_SPLIT_US * `NEAC_OSC_MHZ)
`define NEAC_TICK_W         16

`endif

// File: hw/neac_prog_timer.v
// programming duration timer counting calibrated oscillator edges
`timescale 1ns/100ps
`include "neac_defines.vh"

module neac_prog_timer #(
    parameter [`NEAC_TICK_W-1:0] ATOMIC_TICKS = `NEAC_ATOMIC_TICKS,
    parameter [`NEAC_TICK_W-1:0] SPLIT_TICKS  = `NEAC_SPLIT_TICKS
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // calibrated oscillator pin
    input  wire       osc_in,
    // control
    input  wire       start,
    input  wire [1:0] mode,
    // status
    output wire       busy,
    output wire       done
);

    reg                    osc_s1_q;
    reg                    osc_s2_q;
    reg                    osc_s3_q;
    reg                    osc_lvl_q;
    reg                    run_q;
    reg                    done_q;
    reg [`NEAC_TICK_W-1:0] cnt_q;
    reg [`NEAC_TICK_W-1:0] term_q;
    wire                   tick;

    // oscillator edge counts only once stages two and three agree
    assign tick = osc_s2_q & osc_s3_q & ~osc_lvl_q;
    assign busy = run_q;
    assign done = done_q;

    always @(posedge clk) begin
        osc_s1_q <= osc_in;
        osc_s2_q <= osc_s1_q;
        osc_s3_q <= osc_s2_q;
        if (!rst_n) begin
            osc_lvl_q <= 1'b0;
        end else if (osc_s2_q == osc_s3_q) begin
            osc_lvl_q <= osc_s3_q;
        end
    end

    // [RL17] oscillator timed duration
    always @(posedge clk) begin
        if (!rst_n) begin
            run_q  <= 1'b0;
            done_q <= 1'b0;
            cnt_q  <= {`NEAC_TICK_W{1'b0}};
            term_q <= {`NEAC_TICK_W{1'b0}};
        end else begin
            done_q <= 1'b0;
            if (start && !run_q) begin
                run_q  <= 1'b1;
                cnt_q  <= {`NEAC_TICK_W{1'b0}};
                term_q <= (mode == `NEAC_MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;
            end else if (run_q && tick) begin
                if (cnt_q == term_q - 1'b1) begin
                    run_q  <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

endmodule

// File: hw/neac_unit.v
// data nonvolatile storage with cpu i/o access registers
`timescale 1ns/100ps
`include "neac_defines.vh"

// What this block does
// [RL1] 512 independent byte locations, each readable and writable alone.
// [RL2] control, address and data registers sit in the cpu i/o space.
// [RL3] nine-bit address in bits 8..0 of the high/low address pair.
// [RL4] address bits 15..9 read zero; writes to them do nothing.
// [RL5] addresses run linearly from 0 to 511.
// [RL6] address undefined after reset; software loads it before any access.
// [RL7] a write programs the data register byte at the addressed location.
// [RL8] a read loads the data register from the addressed location.
// [RL9] a read stalls the cpu four cycles.
// [RL10] launching a write stalls the cpu two cycles.
// [RL11] writes self time; software polls the write strobe for completion.
// [RL12] a write starts only after the arming sequence, every time.
// [RL13] arming opens a four cycle window; strobe outside it is ignored.
// [RL14] hardware clears the write strobe when programming time has elapsed.
// [RL15] mode 00 erase+write 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved.
// [RL16] while writing, reads are ignored and the address cannot change.
// [RL17] duration counted on the calibrated oscillator, per mode terminal count.
module neac_unit #(
    parameter [`NEAC_TICK_W-1:0] ATOMIC_TICKS = `NEAC_ATOMIC_TICKS,
    parameter [`NEAC_TICK_W-1:0] SPLIT_TICKS  = `NEAC_SPLIT_TICKS
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // calibrated oscillator pin
    input  wire       osc_in,
    // cpu i/o register port
    input  wire [5:0] io_addr,
    input  wire [7:0] io_wdata,
    input  wire       io_we,
    input  wire       io_re,
    output wire [7:0] io_rdata,
    // cpu halt request
    output wire       cpu_stall
);

    // storage array
    reg [7:0]             mem_q [0:`NEAC_DEPTH-1];

    // register state
    reg [`NEAC_AW-1:0]    addr_q;
    reg [7:0]             data_q;
    reg [1:0]             mode_q;
    reg [1:0]             busy_mode_q;
    reg [`NEAC_AW-1:0]    busy_addr_q;
    reg [7:0]             busy_data_q;
    reg                   arm_q;
    reg [2:0]             arm_cnt_q;
    reg                   wr_strobe_q;
    reg [2:0]             stall_cnt_q;
    reg [7:0]             rdata_q;

    // decoded accesses
    wire                  wr_ctrl;
    wire                  wr_data;
    wire                  wr_alo;
    wire                  wr_ahi;
    wire                  rd_req;
    wire                  wr_start;
    wire                  prog_done;
    wire [7:0]            ctrl_view;
    wire [7:0]            prog_byte;

    // one-hot register select, used by the write decode only; the read path has its own case
    function sel;
        input [5:0] a;
        input [5:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    // [RL2] i/o space decode
    assign wr_ctrl = io_we & sel(io_addr, `NEAC_OFF_CTRL);
    assign wr_data = io_we & sel(io_addr, `NEAC_OFF_DATA);
    assign wr_alo  = io_we & sel(io_addr, `NEAC_OFF_ADDR_LO);
    assign wr_ahi  = io_we & sel(io_addr, `NEAC_OFF_ADDR_HI);

    // [RL16] read refused while busy
    assign rd_req = wr_ctrl & io_wdata[`NEAC_CTRL_RD_BIT] & ~wr_strobe_q;

    // [RL12] strobe only counts when armed
    // [RL13] arm must be set before this cycle
    assign wr_start = wr_ctrl & io_wdata[`NEAC_CTRL_WR_BIT] & arm_q & ~wr_strobe_q;

    // read strobe self clears, so it always reads zero
    assign ctrl_view = {2'b00, mode_q, 1'b0, arm_q, wr_strobe_q, 1'b0};

    assign io_rdata  = rdata_q;
    assign cpu_stall = (stall_cnt_q != 3'h0);

    // [RL17] timer on calibrated oscillator
    neac_prog_timer #(
        .ATOMIC_TICKS (ATOMIC_TICKS),
        .SPLIT_TICKS  (SPLIT_TICKS)
    ) u_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .osc_in (osc_in),
        .start  (wr_start),
        .mode   (mode_q),
        .busy   (),
        .done   (prog_done)
    );

    // [RL15] byte result per programming mode
    // erase-only leaves the blank value, write-only can only clear bits
    function [7:0] byte_after_prog;
        input [1:0] m;
        input [7:0] old;
        input [7:0] d;
        begin
            case (m)
                `NEAC_MODE_ATOMIC: begin
                    byte_after_prog = d;
                end
                `NEAC_MODE_ERASE: begin
                    byte_after_prog = `NEAC_ERASED_BYTE;
                end
                `NEAC_MODE_WRITE: begin
                    byte_after_prog = old & d;
                end
                default: begin
                    // reserved code must not disturb stored data
                    byte_after_prog = old;
                end
            endcase
        end
    endfunction

    assign prog_byte = byte_after_prog(busy_mode_q, mem_q[busy_addr_q], busy_data_q);

    // address pair
    always @(posedge clk) begin
        if (!rst_n) begin
            // [RL6] defined value only for simulation hygiene
            addr_q <= `NEAC_RST_ADDR;
        end else if (!wr_strobe_q) begin
            // [RL16] address frozen during a write
            // [RL3] low byte and bit 8 from high byte
            if (wr_alo) begin
                addr_q[7:0] <= io_wdata;
            end
            // [RL4] upper high-byte bits dropped
            if (wr_ahi) begin
                addr_q[8] <= io_wdata[0];
            end
        end
    end

    // data register
    always @(posedge clk) begin
        if (!rst_n) begin
            data_q <= `NEAC_RST_DATA;
        end else if (rd_req) begin
            // [RL8] read loads data register at once
            // [RL5] linear addressing into the array
            data_q <= mem_q[addr_q];
        end else if (wr_data) begin
            data_q <= io_wdata;
        end
    end

    // mode field and arming window
    always @(posedge clk) begin
        if (!rst_n) begin
            mode_q    <= `NEAC_RST_MODE;
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'h0;
        end else begin
            // mode writes ignored while the strobe is set
            if (wr_ctrl && !wr_strobe_q) begin
                mode_q <= io_wdata[`NEAC_CTRL_MODE_HI:`NEAC_CTRL_MODE_LO];
            end
            // [RL13] four cycle arming window, new arm wins over expiry
            if (wr_ctrl && io_wdata[`NEAC_CTRL_ARM_BIT]) begin
                arm_q     <= 1'b1;
                arm_cnt_q <= `NEAC_ARM_WINDOW;
            end else if (arm_q) begin
                if (arm_cnt_q == 3'h1) begin
                    arm_q <= 1'b0;
                end
                arm_cnt_q <= arm_cnt_q - 3'h1;
            end
        end
    end

    // write strobe and captured operands
    always @(posedge clk) begin
        if (!rst_n) begin
            wr_strobe_q <= 1'b0;
            busy_mode_q <= `NEAC_RST_MODE;
            busy_addr_q <= `NEAC_RST_ADDR;
            busy_data_q <= `NEAC_RST_DATA;
        end else if (wr_start) begin
            // [RL7] capture address and data byte for programming
            wr_strobe_q <= 1'b1;
            busy_mode_q <= mode_q;
            busy_addr_q <= addr_q;
            busy_data_q <= data_q;
        end else if (prog_done) begin
            // [RL14] hardware clears strobe at end
            // [RL11] strobe doubles as the poll status
            wr_strobe_q <= 1'b0;
        end
    end

    // storage update; reserved mode keeps the old byte
    // [RL1] single byte programmed per operation
    always @(posedge clk) begin
        if (rst_n && prog_done && wr_strobe_q) begin
            mem_q[busy_addr_q] <= prog_byte;
        end
    end

    // cpu halt counter
    always @(posedge clk) begin
        if (!rst_n) begin
            stall_cnt_q <= 3'h0;
        end else if (rd_req) begin
            // [RL9] four cycle halt on read
            stall_cnt_q <= `NEAC_RD_STALL;
        end else if (wr_start) begin
            // [RL10] two cycle halt on write launch
            stall_cnt_q <= `NEAC_WR_STALL;
        end else if (stall_cnt_q != 3'h0) begin
            stall_cnt_q <= stall_cnt_q - 3'h1;
        end
    end

    // registered read data; unmapped offsets read zero
    always @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (io_re) begin
            case (io_addr)
                `NEAC_OFF_CTRL: begin
                    rdata_q <= ctrl_view;
                end
                `NEAC_OFF_DATA: begin
                    rdata_q <= data_q;
                end
                `NEAC_OFF_ADDR_LO: begin
                    rdata_q <= addr_q[7:0];
                end
                `NEAC_OFF_ADDR_HI: begin
                    // [RL4] reserved bits read zero
                    rdata_q <= {7'h00, addr_q[8]};
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end

endmodule

// File: verification/neac_unit_sva.sv
// port checker for the nonvolatile access unit
`timescale 1ns/100ps
`include "neac_defines.vh"
module neac_unit_sva #(
    parameter [`NEAC_TICK_W-1:0] ATOMIC_TICKS = `NEAC_ATOMIC_TICKS,
    parameter [`NEAC_TICK_W-1:0] SPLIT_TICKS  = `NEAC_SPLIT_TICKS
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       osc_in,
    // cpu port
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       io_we,
    input wire logic       io_re,
    input wire logic [7:0] io_rdata,
    input wire logic       cpu_stall
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic       ctl_wr;
    logic [2:0] arm_age_q;
    assign ctl_wr = io_we && io_addr == `NEAC_OFF_CTRL;
    // saturates so a stale arm never reopens the window
    always @(posedge clk) begin
        if (!rst_n) arm_age_q <= 3'h7;
        else if (ctl_wr && io_wdata[2]) arm_age_q <= 3'h1;
        else if (arm_age_q != 3'h7) arm_age_q <= arm_age_q + 3'h1;
    end
    property p_rd_stall;
        ctl_wr && io_wdata[2:0] == 3'h1 ##1 cpu_stall |-> cpu_stall[*4] ##1 !cpu_stall;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");
    property p_wr_stall;
        ctl_wr && io_wdata[2:1] == 2'h2 ##[1:4] ctl_wr && io_wdata[2:0] == 3'h2 ##1 cpu_stall
            |-> cpu_stall[*2] ##1 !cpu_stall;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall length wrong");
    property p_window;
        ctl_wr && io_wdata[2:0] == 3'h2 && arm_age_q > 3'h4 && !cpu_stall |=> !cpu_stall;
    endproperty
    a_window: assert property (p_window) else $error("strobe outside arm window taken");
    property p_stall_len;
        $rose(cpu_stall) |-> ##1 cpu_stall ##1 (!cpu_stall or (cpu_stall[*2] ##1 !cpu_stall));
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall neither two nor four");
    property p_stall_cause;
        $rose(cpu_stall) |-> $past(ctl_wr);
    endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("stall without control write");
    property p_hi_zero;
        io_re && io_addr == `NEAC_OFF_ADDR_HI |=> io_rdata[7:1] == 7'h00;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("address high spare bits set");
    property p_ctl_rsvd;
        io_re && io_addr == `NEAC_OFF_CTRL |=> io_rdata[0] == 1'b0 && io_rdata[3] == 1'b0
            && io_rdata[7:6] == 2'h0;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control spare bits set");
    property p_hold;
        !io_re |=> $stable(io_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without strobe");
    property p_unmapped;
        io_re && io_addr > 6'h03 |=> io_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped offset not zero");
    c_rd: cover property (p_rd_stall);
    c_wr: cover property (p_wr_stall);
    c_late: cover property (ctl_wr && io_wdata[2:1] == 2'h1 && arm_age_q > 3'h4);
endmodule
bind neac_unit neac_unit_sva #(.ATOMIC_TICKS(ATOMIC_TICKS), .SPLIT_TICKS(SPLIT_TICKS)) u_sva (
    .clk(clk), .rst_n(rst_n), .osc_in(osc_in), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .cpu_stall(cpu_stall));

// File: verification/neac_cpu_model.sv
// cpu core model issuing i/o register accesses
`timescale 1ns/100ps
`include "neac_defines.vh"
module neac_cpu_model (
    // clock
    input wire logic       clk,
    // i/o register port
    output logic     [5:0] io_addr,
    output logic     [7:0] io_wdata,
    output logic           io_we,
    output logic           io_re,
    input wire logic [7:0] io_rdata,
    input wire logic       cpu_stall
);
    int hang = 0;
    initial begin
        io_addr = 6'h3F;
        io_wdata = 8'h00;
        io_we = 1'b0;
        io_re = 1'b0;
    end
    // halted core issues nothing until stall drops
    task automatic hold_off();
        int k;
        k = 0;
        @(negedge clk);
        while (cpu_stall && k < 16) begin
            @(negedge clk);
            k++;
        end
        if (k == 16) hang++;
    endtask
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        hold_off();
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(negedge clk);
        io_we = 1'b0;
        // released data bus must not keep the last value
        io_wdata = ~d;
    endtask
    task automatic get(input logic [5:0] a, output logic [7:0] d);
        hold_off();
        io_addr = a;
        io_re = 1'b1;
        @(negedge clk);
        io_re = 1'b0;
        @(negedge clk);
        d = io_rdata;
    endtask
    task automatic write_byte(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
        put(`NEAC_OFF_ADDR_LO, a[7:0]);
        put(`NEAC_OFF_ADDR_HI, {7'h00, a[8]});
        put(`NEAC_OFF_DATA, d);
        put(`NEAC_OFF_CTRL, {2'h0, m, 4'h4});
        put(`NEAC_OFF_CTRL, {2'h0, m, 4'h2});
    endtask
    task automatic read_byte(input logic [8:0] a, output logic [7:0] d);
        put(`NEAC_OFF_ADDR_LO, a[7:0]);
        put(`NEAC_OFF_ADDR_HI, {7'h00, a[8]});
        put(`NEAC_OFF_CTRL, 8'h01);
        get(`NEAC_OFF_DATA, d);
    endtask
endmodule

// File: verification/data_eeprom_access_unit_tb.sv
// self-checking bench for the nonvolatile access unit
`timescale 1ns/100ps
`include "neac_defines.vh"
module data_eeprom_access_unit_tb;
    // short terminal counts keep the run brief
    localparam logic [15:0] AT = 16'h0006;
    localparam logic [15:0] ST = 16'h0003;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       osc_in = 1'b0;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       io_we;
    logic       io_re;
    logic       cpu_stall;
    logic [7:0] shadow [0:511];
    logic [7:0] got;
    int         fails = 0;
    int         n_tests = 0;
    int         cyc = 0;
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // a stall that never drops ends the run at once
    always @(negedge clk) begin
        if (cpu.hang != 0) wrap_up();
    end
    always #62.5 osc_in = ~osc_in;
    neac_unit #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) DUT (.clk(clk), .rst_n(rst_n), .osc_in(osc_in),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
        .cpu_stall(cpu_stall));
    neac_cpu_model cpu (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
        .io_rdata(io_rdata), .cpu_stall(cpu_stall));
    task automatic wrap_up();
        fails += cpu.hang;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] prog_result(input logic [1:0] m, input logic [7:0] old, input logic [7:0] d);
        case (m)
            2'h0: prog_result = d;
            2'h1: prog_result = 8'hFF;
            2'h2: prog_result = old & d;
            default: prog_result = old;
        endcase
    endfunction
    task automatic wait_idle();
        int k;
        k = 0;
        got = 8'h02;
        while (got[1] !== 1'b0 && k < 200) begin
            cpu.get(`NEAC_OFF_CTRL, got);
            k++;
        end
        if (k == 200) begin
            fails++;
            $display("[ERR] write strobe expected 0 seen %h", got);
            wrap_up();
        end
    endtask
    // duration window: osc period is about 15.6 clocks, plus sync and poll slack
    task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
        int   t0;
        int   n;
        logic ok;
        cpu.write_byte(a, d, m);
        t0 = cyc;
        wait_idle();
        n = (m == 2'h0) ? AT : ST;
        ok = ((cyc - t0) >= 15 * (n - 1)) && ((cyc - t0) <= 16 * n + 8);
        check("prog time", 8'h01, {7'h00, ok});
        shadow[a] = prog_result(m, shadow[a], d);
    endtask
    initial begin
        logic [8:0] a;
        void'($urandom(95965));
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        cpu.get(`NEAC_OFF_CTRL, got);
        check("ctrl reset", 8'h00, got);
        cpu.put(`NEAC_OFF_ADDR_HI, 8'hFF);
        cpu.get(`NEAC_OFF_ADDR_HI, got);
        check("addr_hi", 8'h01, got);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($urandom_range(511));
            prog(a, 8'($urandom), 2'h0);
            prog(a, 8'($urandom), 2'(i));
            cpu.read_byte(a, got);
            check("byte", shadow[a], got);
        end
        $display("test modes done");
        cpu.write_byte(9'h020, 8'hC3, 2'h0);
        cpu.put(`NEAC_OFF_ADDR_LO, 8'h77);
        cpu.put(`NEAC_OFF_CTRL, 8'h01);
        check("busy read stall", 8'h00, {7'h00, cpu_stall});
        cpu.get(`NEAC_OFF_ADDR_LO, got);
        check("busy addr_lo", 8'h20, got);
        cpu.get(`NEAC_OFF_CTRL, got);
        check("busy ctrl", 8'h02, got);
        wait_idle();
        shadow[32] = 8'hC3;
        $display("test busy done");
        cpu.put(`NEAC_OFF_DATA, 8'h11);
        cpu.put(`NEAC_OFF_CTRL, 8'h04);
        repeat (4) @(negedge clk);
        cpu.put(`NEAC_OFF_CTRL, 8'h02);
        check("late strobe stall", 8'h00, {7'h00, cpu_stall});
        cpu.read_byte(9'h020, got);
        check("late strobe byte", 8'hC3, got);
        $display("test window done");
        cpu.get(6'h2A, got);
        check("unmapped", 8'h00, got);
        $display("test unmapped done");
        cpu.put(`NEAC_OFF_CTRL, 8'h34);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        cpu.get(`NEAC_OFF_CTRL, got);
        check("ctrl after reset", 8'h00, got);
        $display("test reset done");
        wrap_up();
    end
    initial begin
        #600000;
        fails++;
        $display("[ERR] run expected end seen hang");
        wrap_up();
    end
endmodule
